/* File: hdl/cbr_regs.sv */
// Retry status, card control and device control registers of the card bridge
`timescale 1ns/1ps
`include "cbr_consts.svh"
module cbr_regs
    import cbr_pkg::*;
#(
    parameter int RETRY_TIMEOUT_CYC = `CBR_RETRY_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Configuration access
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic      [7:0]  cfg_rdata_o,
    output logic             cfg_ack_o,
    // Retry tracking: 0 host target, 1 card target A, 2 card target B
    input  wire logic [2:0]  retry_issued_i,
    input  wire logic [2:0]  master_returned_i,
    // Card pins
    input  wire logic        card_func_irq_i,
    input  wire logic        card_ring_i,
    input  wire logic        card_audio_signal_i,
    input  wire logic        card_speaker_in_i,
    // Ring routing
    input  wire logic        ring_pin_select_i,
    output logic             ring_wake_pin_o,
    output logic             multi_pin_two_o,
    output logic             multi_pin_four_o,
    // Audio, speaker and video
    output logic             card_audio_pwm_out_o,
    output logic             speaker_out_pin_o,
    output logic             speaker_out_oe_n_o,
    output logic             video_port_oe_n_o,
    // Socket power
    input  wire logic        in_d3_i,
    input  wire logic        sock_pwr_down_req_i,
    output logic             sock_pwr_down_ok_o,
    output logic             socket_power_hold_o,
    // Device behaviour
    output logic             low_volt_capable_force_o,
    output logic             legacy_io_diag_o,
    output cbr_irq_mode_e    irq_signal_mode_o
);

    ////////////////////////////////////////////////////////////////////////
    // Storage and helpers

    logic [7:0] retry_q;
    logic [7:0] card_q;
    logic [7:0] dev_q;
    logic [2:0] expired;
    logic       irq_s;
    logic       ring_s;
    logic       audio_s;
    logic       card_speaker_in_s;
    logic       wr_retry;
    logic       wr_card;
    logic       wr_dev;

    function automatic logic [7:0] wr_update(input logic [7:0] cur,
                                             input logic [7:0] wdata,
                                             input logic [7:0] rw_mask,
                                             input logic [7:0] w1c_mask,
                                             input logic [7:0] set,
                                             input logic       hit);
        logic [7:0] nv;
        nv = cur;
        if (hit) begin
            nv = (cur & ~rw_mask) | (wdata & rw_mask);
            nv = nv & ~(wdata & w1c_mask);
        end
        return nv | (set & w1c_mask);
    endfunction

    function automatic logic is_write(input logic [7:0] ofs);
        return cfg_wr_i && (cfg_addr_i == ofs);
    endfunction

    // Write decodes as nets, so the checks see sampled values
    assign wr_retry = is_write(`CBR_OFS_RETRY);
    assign wr_card  = is_write(`CBR_OFS_CARD);
    assign wr_dev   = is_write(`CBR_OFS_DEV);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    cbr_sync #(.W(4)) u_pin_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    ({card_func_irq_i, card_ring_i, card_audio_signal_i, card_speaker_in_i}),
        .q_o    ({irq_s, ring_s, audio_s, card_speaker_in_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // Retry timeout watchers

    cbr_retry_if rif[3] ();

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_watch
            assign rif[g].start = retry_issued_i[g];
            assign rif[g].back  = master_returned_i[g];
            if (g == 0) begin : g_host
                assign rif[g].en = retry_q[`CBR_HOST_CNT_EN];
            end else begin : g_card
                assign rif[g].en = retry_q[`CBR_CARD_CNT_EN];
            end
            assign expired[g] = rif[g].expired;

            cbr_retry_watch #(.TIMEOUT_CYC(RETRY_TIMEOUT_CYC)) u_watch (
                .clk_i  (clk_i),
                .srst_i (srst_i),
                .rw     (rif[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register updates

    // Expiry flags at 1, 3, 5; set wins over clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            retry_q <= `CBR_RST_RETRY;
        end else begin
            retry_q <= wr_update(retry_q, cfg_wdata_i, `CBR_RW_RETRY, `CBR_W1C_RETRY,
                                 {2'b00, expired[2], 1'b0, expired[1], 1'b0,
                                  expired[0], 1'b0},
                                 is_write(`CBR_OFS_RETRY));
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            card_q <= `CBR_RST_CARD;
        end else begin
            card_q <= wr_update(card_q, cfg_wdata_i, `CBR_RW_CARD, `CBR_W1C_CARD,
                                {7'h00, irq_s},
                                is_write(`CBR_OFS_CARD));
        end
    end

    // Test and reserved bits 3 and 0 are stored as written; bit 4 is always stored as 0
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dev_q <= `CBR_RST_DEV;
        end else if (is_write(`CBR_OFS_DEV)) begin
            dev_q <= cfg_wdata_i & `CBR_RW_DEV;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg_rdata_o <= 8'h00;
            cfg_ack_o   <= 1'b0;
        end else begin
            cfg_ack_o <= cfg_rd_i || cfg_wr_i;
            if (cfg_rd_i) begin
                unique case (cfg_addr_i)
                    `CBR_OFS_RETRY: cfg_rdata_o <= retry_q
                                                   & (`CBR_RW_RETRY | `CBR_W1C_RETRY);
                    `CBR_OFS_CARD:  cfg_rdata_o <= card_q & (`CBR_RW_CARD | `CBR_W1C_CARD);
                    `CBR_OFS_DEV:   cfg_rdata_o <= dev_q & `CBR_RW_DEV;
                    default:        cfg_rdata_o <= 8'h00;
                endcase
            end else begin
                cfg_rdata_o <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Signal routing

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ring_wake_pin_o  <= 1'b0;
            multi_pin_two_o  <= 1'b0;
            multi_pin_four_o <= 1'b0;
        end else begin
            ring_wake_pin_o  <= card_q[`CBR_RING_EN] && !ring_pin_select_i && ring_s;
            multi_pin_two_o  <= card_q[`CBR_RING_EN] && ring_s;
            multi_pin_four_o <= card_q[`CBR_RING_EN] && ring_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            card_audio_pwm_out_o <= 1'b0;
            speaker_out_pin_o    <= 1'b0;
        end else begin
            card_audio_pwm_out_o <= card_q[`CBR_AUDIO_EN] && audio_s;
            speaker_out_pin_o    <= card_q[`CBR_CARD_SPEAKER_IN_EN] && card_speaker_in_s;
        end
    end

    assign speaker_out_oe_n_o = !card_q[`CBR_CARD_SPEAKER_IN_EN];
    assign video_port_oe_n_o  = card_q[`CBR_VIDEO_EN];

    ////////////////////////////////////////////////////////////////////////
    // Device behaviour outputs

    assign socket_power_hold_o      = dev_q[`CBR_PWR_HOLD];
    assign sock_pwr_down_ok_o       = sock_pwr_down_req_i
                                      && !(dev_q[`CBR_PWR_HOLD] && in_d3_i);
    assign low_volt_capable_force_o = dev_q[`CBR_LV_CAP];
    assign legacy_io_diag_o         = dev_q[`CBR_DIAG];
    assign irq_signal_mode_o        = cbr_irq_mode_e'(dev_q[`CBR_MODE_HI:`CBR_MODE_LO]);

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_reset_values: assert property (
        disable iff (1'b0) $past(srst_i) && !srst_i |-> (retry_q == `CBR_RST_RETRY)
            && (card_q == `CBR_RST_CARD) && (dev_q == `CBR_RST_DEV))
        else $error("register reset value wrong");

    a_host_expiry_set: assert property (
        expired[0] |=> retry_q[1])
        else $error("host expiry flag not set");

    a_card_expiry_set: assert property (
        expired[2] && wr_retry && cfg_wdata_i[5] |=> retry_q[5])
        else $error("card B expiry lost to clear");

    a_expiry_clear: assert property (
        wr_retry && cfg_wdata_i[3] && !expired[1] |=> !retry_q[3])
        else $error("card A expiry not cleared");

    a_host_count_off: assert property (
        !retry_q[`CBR_HOST_CNT_EN] |=> !$rose(retry_q[1]))
        else $error("host flag set while counter disabled");

    a_card_count_off: assert property (
        !retry_q[`CBR_CARD_CNT_EN] |=> !$rose(retry_q[3]) && !$rose(retry_q[5]))
        else $error("card flag set while counter disabled");

    a_reserved_read: assert property (
        cfg_rd_i && (cfg_addr_i == `CBR_OFS_RETRY) |=> cfg_ack_o
            && (cfg_rdata_o[4] == 1'b0) && (cfg_rdata_o[2] == 1'b0) && (cfg_rdata_o[0] == 1'b0))
        else $error("retry reserved bit read nonzero");

    a_card_reserved: assert property (
        cfg_rd_i && (cfg_addr_i == `CBR_OFS_CARD) |=> cfg_rdata_o[4:3] == 2'b00)
        else $error("card reserved bits read nonzero");

    a_ring_route: assert property (
        !card_q[`CBR_RING_EN] |=> !ring_wake_pin_o && !multi_pin_two_o && !multi_pin_four_o)
        else $error("ring routed while disabled");

    a_speaker_drive: assert property (
        wr_card && cfg_wdata_i[`CBR_CARD_SPEAKER_IN_EN] |=> !speaker_out_oe_n_o
            ##1 (speaker_out_pin_o == $past(card_speaker_in_s)))
        else $error("speaker not driven after enable");

    a_irq_flag_set: assert property (
        irq_s |=> card_q[`CBR_IRQ_FLAG])
        else $error("card interrupt flag not set");

    a_irq_flag_hold: assert property (
        card_q[`CBR_IRQ_FLAG] && !(wr_card && cfg_wdata_i[0])
            |=> card_q[`CBR_IRQ_FLAG])
        else $error("card interrupt flag cleared without write");

    a_power_hold: assert property (
        dev_q[`CBR_PWR_HOLD] && in_d3_i |-> !sock_pwr_down_ok_o)
        else $error("socket power-down allowed while held");

    a_mode_write: assert property (
        wr_dev |=> irq_signal_mode_o == cbr_irq_mode_e'($past(cfg_wdata_i[2:1])))
        else $error("interrupt mode not written");

    a_video_float: assert property (
        wr_card |=> video_port_oe_n_o == $past(cfg_wdata_i[`CBR_VIDEO_EN]))
        else $error("video terminals not floated as written");

    a_flag_zero_write: assert property (
        wr_retry && retry_q[3] && !cfg_wdata_i[3] |=> retry_q[3])
        else $error("expiry flag lost on zero write");

    a_audio_route: assert property (
        !card_q[`CBR_AUDIO_EN] |=> !card_audio_pwm_out_o)
        else $error("card audio routed while disabled");

endmodule

/* File: hdl/cbr_retry_watch.sv */
// Retry timeout counter for one retried master
`timescale 1ns/1ps
`include "cbr_consts.svh"
module cbr_retry_watch #(
    parameter int TIMEOUT_CYC = `CBR_RETRY_CYC
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Register bank side
    cbr_retry_if.watch rw
);
    localparam int CW = (TIMEOUT_CYC > 1) ? $clog2(TIMEOUT_CYC) : 1;
    localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

    logic          busy;
    logic [CW-1:0] cnt;

    // Disabled counter never runs; a returning master stops the wait
    always_ff @(posedge clk_i) begin
        if (srst_i || !rw.en || rw.back) begin
            busy <= 1'b0;
            cnt  <= '0;
        end else if (rw.start) begin
            busy <= 1'b1;
            cnt  <= '0;
        end else if (busy) begin
            if (cnt == LAST) begin
                busy <= 1'b0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    assign rw.expired = busy && rw.en && !rw.back && !rw.start && (cnt == LAST);
endmodule

/* File: hdl/cbr_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module cbr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

/* File: shared/cbr_consts.svh */
// Register map, field positions, reset values and timing for the card bridge registers
`ifndef CBR_CONSTS_SVH
`define CBR_CONSTS_SVH

// Byte offsets in configuration space
`define CBR_OFS_RETRY        8'h90
`define CBR_OFS_CARD         8'h91
`define CBR_OFS_DEV          8'h92

// Reset values
`define CBR_RST_RETRY        8'hC0
`define CBR_RST_CARD         8'h00
`define CBR_RST_DEV          8'h66

// Writable and write-one-to-clear masks
`define CBR_RW_RETRY         8'hC0
`define CBR_W1C_RETRY        8'h2A
`define CBR_RW_CARD          8'hE6
`define CBR_W1C_CARD         8'h01
`define CBR_RW_DEV           8'hEF

// Retry status fields
`define CBR_HOST_CNT_EN      7
`define CBR_CARD_CNT_EN      6

// Card control fields
`define CBR_RING_EN          7
`define CBR_VIDEO_EN         6
`define CBR_AUDIO_EN         2
`define CBR_CARD_SPEAKER_IN_EN          1
`define CBR_IRQ_FLAG         0

// Device control fields
`define CBR_PWR_HOLD         7
`define CBR_LV_CAP           6
`define CBR_DIAG             5
`define CBR_MODE_HI          2
`define CBR_MODE_LO          1

// Retry timeout: two to this power of clock cycles
`define CBR_RETRY_EXP        15
`define CBR_RETRY_CYC        (1 << `CBR_RETRY_EXP)

`endif

/* File: shared/cbr_pkg.sv */
// Types shared by the card bridge register block
package cbr_pkg;

    typedef enum logic [1:0] {
        CBR_IRQ_PAR_PCI,
        CBR_IRQ_PAR_IRQ_PAR_PCI,
        CBR_IRQ_SER_IRQ_PAR_PCI,
        CBR_IRQ_SER_ALL
    } cbr_irq_mode_e;

endpackage

/* File: shared/cbr_retry_if.sv */
// Link between the register bank and one retry timeout watcher
`timescale 1ns/1ps
interface cbr_retry_if;
    logic start;
    logic back;
    logic en;
    logic expired;

    modport watch (input start, input back, input en, output expired);
    modport ctl   (output start, output back, output en, input expired);
endinterface

/* File: testbench/cbr_far_model.sv */
// Far-side model: retried masters and card socket pins
`timescale 1ns/1ps
module cbr_far_model (
    // Clock
    input  wire logic       clk_i,
    // Retry tracking
    output logic      [2:0] retry_issued_o,
    output logic      [2:0] master_returned_o,
    // Card pins
    output logic            card_func_irq_o,
    output logic            card_ring_o,
    output logic            card_audio_o,
    output logic            card_speaker_o
);
    initial begin
        retry_issued_o    = 3'h0;
        master_returned_o = 3'h0;
        card_func_irq_o   = 1'b0;
        card_ring_o       = 1'b0;
        card_audio_o      = 1'b0;
        card_speaker_o    = 1'b0;
    end

    // Retry the given masters; they come back after a delay, or never if zero
    task automatic retry(input logic [2:0] grp, input int back_after);
        @(posedge clk_i);
        retry_issued_o <= grp;
        @(posedge clk_i);
        retry_issued_o <= 3'h0;
        if (back_after > 0) begin
            repeat (back_after - 1) @(posedge clk_i);
            master_returned_o <= grp;
            @(posedge clk_i);
            master_returned_o <= 3'h0;
        end
    endtask

    task automatic pins(input logic ring, input logic aud, input logic spk);
        @(posedge clk_i);
        card_ring_o    <= ring;
        card_audio_o   <= aud;
        card_speaker_o <= spk;
    endtask

    task automatic irq_pulse(input int n);
        @(posedge clk_i);
        card_func_irq_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        card_func_irq_o <= 1'b0;
    endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the card bridge register block
`timescale 1ns/1ps
`include "cbr_consts.svh"
module tb_top;
    import cbr_pkg::*;

    logic          clk_i = 1'b0;
    logic          srst_i = 1'b1;
    logic [7:0]    cfg_addr_i = 8'h00;
    logic          cfg_wr_i = 1'b0;
    logic          cfg_rd_i = 1'b0;
    logic [7:0]    cfg_wdata_i = 8'h00;
    logic [7:0]    cfg_rdata_o;
    logic          cfg_ack_o;
    logic [2:0]    retry_issued, master_returned;
    logic          f_irq, f_ring, f_aud, f_spk;
    logic          ring_pin_select_i = 1'b0;
    logic          in_d3_i = 1'b0;
    logic          sock_pwr_down_req_i = 1'b0;
    logic          ring_wake, mp2, mp4, pwm, spk, spk_oe_n, vid_oe_n;
    logic          pwr_ok, pwr_hold, lv_cap, diag;
    cbr_irq_mode_e irq_mode;
    int            err_count = 0;
    int            n_checks = 0;
    logic [7:0]    rv;

    always #2 clk_i = ~clk_i;

    cbr_far_model far (.clk_i(clk_i), .retry_issued_o(retry_issued),
        .master_returned_o(master_returned), .card_func_irq_o(f_irq),
        .card_ring_o(f_ring), .card_audio_o(f_aud), .card_speaker_o(f_spk));

    cbr_regs #(.RETRY_TIMEOUT_CYC(16)) dut (.clk_i(clk_i), .srst_i(srst_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
        .retry_issued_i(retry_issued), .master_returned_i(master_returned),
        .card_func_irq_i(f_irq), .card_ring_i(f_ring), .card_audio_signal_i(f_aud),
        .card_speaker_in_i(f_spk), .ring_pin_select_i(ring_pin_select_i),
        .ring_wake_pin_o(ring_wake), .multi_pin_two_o(mp2), .multi_pin_four_o(mp4),
        .card_audio_pwm_out_o(pwm), .speaker_out_pin_o(spk),
        .speaker_out_oe_n_o(spk_oe_n), .video_port_oe_n_o(vid_oe_n),
        .in_d3_i(in_d3_i), .sock_pwr_down_req_i(sock_pwr_down_req_i),
        .sock_pwr_down_ok_o(pwr_ok), .socket_power_hold_o(pwr_hold),
        .low_volt_capable_force_o(lv_cap), .legacy_io_diag_o(diag),
        .irq_signal_mode_o(irq_mode));

    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cfg_addr_i  <= a;
        cfg_wdata_i <= d;
        cfg_wr_i    <= 1'b1;
        @(posedge clk_i);
        cfg_wr_i <= 1'b0;
        #1 cmp("write ack", {7'h00, cfg_ack_o}, 8'h01);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        cfg_addr_i <= a;
        cfg_rd_i   <= 1'b1;
        @(posedge clk_i);
        cfg_rd_i <= 1'b0;
        #1 cmp("read ack", {7'h00, cfg_ack_o}, 8'h01);
        cmp(what, cfg_rdata_o, exp);
    endtask

    function automatic logic [7:0] pins_now();
        return {1'b0, ring_wake, mp2, mp4, pwm, spk, spk_oe_n, vid_oe_n};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        rdchk(`CBR_OFS_RETRY, 8'hC0, "retry reset");
        rdchk(`CBR_OFS_CARD, 8'h00, "card reset");
        rdchk(`CBR_OFS_DEV, 8'h66, "dev reset");
        rdchk(8'h93, 8'h00, "unmapped read");
        cmp("pins reset", pins_now(), 8'h02);
        cmp("mode reset", {6'h00, irq_mode}, 8'h03);
    endtask

    task automatic t_reserved();
        wr(`CBR_OFS_RETRY, 8'hFF);
        rdchk(`CBR_OFS_RETRY, 8'hC0, "retry reserved");
        wr(`CBR_OFS_CARD, 8'hDF);
        rdchk(`CBR_OFS_CARD, 8'hC6, "card reserved");
        wr(`CBR_OFS_CARD, 8'h00);
        wr(`CBR_OFS_DEV, 8'hF6);
        rdchk(`CBR_OFS_DEV, 8'hE6, "dev reserved");
        cmp("dev outputs", {5'h00, pwr_hold, lv_cap, diag}, 8'h07);
    endtask

    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(`CBR_OFS_DEV, 8'h20 | 8'(m << 1));
            cmp("irq mode", {6'h00, irq_mode}, 8'(m));
            cmp("lv and diag", {6'h00, lv_cap, diag}, 8'h01);
        end
        wr(`CBR_OFS_DEV, 8'h66);
    endtask

    task automatic t_retry_expiry();
        far.retry(3'h7, 0);
        repeat (8) @(posedge clk_i);
        rdchk(`CBR_OFS_RETRY, 8'hC0, "retry early");
        repeat (10) @(posedge clk_i);
        rdchk(`CBR_OFS_RETRY, 8'hEA, "retry expired");
        wr(`CBR_OFS_RETRY, 8'hC0);
        rdchk(`CBR_OFS_RETRY, 8'hEA, "zero write keeps");
        wr(`CBR_OFS_RETRY, 8'hC2);
        rdchk(`CBR_OFS_RETRY, 8'hE8, "host clear");
        wr(`CBR_OFS_RETRY, 8'hC8);
        rdchk(`CBR_OFS_RETRY, 8'hE0, "card a clear");
        wr(`CBR_OFS_RETRY, 8'hE0);
        rdchk(`CBR_OFS_RETRY, 8'hC0, "card b clear");
        far.retry(3'h7, 5);
        repeat (25) @(posedge clk_i);
        rdchk(`CBR_OFS_RETRY, 8'hC0, "returned master");
        far.retry(3'h4, 0);
        repeat (14) @(posedge clk_i);
        wr(`CBR_OFS_RETRY, 8'hE0);
        rdchk(`CBR_OFS_RETRY, 8'hE0, "set beats clear");
        wr(`CBR_OFS_RETRY, 8'hE0);
    endtask

    task automatic t_retry_enable();
        logic [7:0] en [3]  = '{8'h80, 8'h40, 8'h00};
        logic [7:0] exp [3] = '{8'h82, 8'h68, 8'h00};
        for (int i = 0; i < 3; i++) begin
            wr(`CBR_OFS_RETRY, en[i]);
            far.retry(3'h7, 0);
            repeat (25) @(posedge clk_i);
            rdchk(`CBR_OFS_RETRY, exp[i], "counter enable");
            wr(`CBR_OFS_RETRY, 8'hEA);
        end
    endtask

    task automatic t_card_irq();
        far.irq_pulse(3);
        repeat (6) @(posedge clk_i);
        rdchk(`CBR_OFS_CARD, 8'h01, "irq set");
        wr(`CBR_OFS_CARD, 8'h00);
        rdchk(`CBR_OFS_CARD, 8'h01, "irq zero write");
        wr(`CBR_OFS_CARD, 8'h01);
        rdchk(`CBR_OFS_CARD, 8'h00, "irq cleared");
        fork
            far.irq_pulse(12);
            begin
                repeat (4) @(posedge clk_i);
                wr(`CBR_OFS_CARD, 8'h01);
            end
        join
        repeat (4) @(posedge clk_i);
        rdchk(`CBR_OFS_CARD, 8'h01, "irq set beats clear");
        wr(`CBR_OFS_CARD, 8'h01);
        rdchk(`CBR_OFS_CARD, 8'h00, "irq clear after pulse");
    endtask

    task automatic t_routing();
        far.pins(1'b1, 1'b1, 1'b1);
        wr(`CBR_OFS_CARD, 8'h86);
        repeat (5) @(posedge clk_i);
        #1 cmp("routes on", pins_now(), 8'h7C);
        far.pins(1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        #1 cmp("routes follow pins", pins_now(), 8'h00);
        far.pins(1'b1, 1'b1, 1'b1);
        ring_pin_select_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 cmp("ring select one", pins_now(), 8'h3C);
        wr(`CBR_OFS_CARD, 8'h40);
        repeat (2) @(posedge clk_i);
        #1 cmp("routes off", pins_now(), 8'h03);
        far.pins(1'b0, 1'b0, 1'b0);
        ring_pin_select_i <= 1'b0;
        wr(`CBR_OFS_CARD, 8'h00);
    endtask

    task automatic t_power();
        wr(`CBR_OFS_DEV, 8'hE6);
        @(posedge clk_i);
        sock_pwr_down_req_i <= 1'b1;
        in_d3_i             <= 1'b1;
        #1 cmp("lock in d3", {7'h00, pwr_ok}, 8'h00);
        @(posedge clk_i);
        in_d3_i <= 1'b0;
        #1 cmp("lock out of d3", {7'h00, pwr_ok}, 8'h01);
        wr(`CBR_OFS_DEV, 8'h66);
        @(posedge clk_i);
        in_d3_i <= 1'b1;
        #1 cmp("no lock in d3", {7'h00, pwr_ok}, 8'h01);
    endtask

    task automatic t_mid_reset();
        wr(`CBR_OFS_CARD, 8'h86);
        wr(`CBR_OFS_DEV, 8'hE6);
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        rdchk(`CBR_OFS_CARD, 8'h00, "card after reset");
        rdchk(`CBR_OFS_DEV, 8'h66, "dev after reset");
        cmp("pins after reset", pins_now(), 8'h02);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #40000;
        err_count++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset_values();
        t_reserved();
        t_modes();
        t_retry_expiry();
        t_retry_enable();
        t_card_irq();
        t_routing();
        t_power();
        t_mid_reset();
        final_report();
    end
endmodule
